// >>> verif/nvm_model.sv
`timescale 1ns/10ps
// Factory byte store beside the loader; answers on the clock after the index
module nvm_model #(
   parameter logic [39:0] CONTENT = 40'h5A_C3_69_F0_1E
) (
   input wire logic clk,
   input wire logic [2:0] nvmAddr,
   output logic [7:0] nvmData = 8'h00
);
   // Out-of-range indexes toggle the bus so a stray capture never looks valid
   always_ff @(posedge clk) begin
      if (nvmAddr < 3'h5) begin
         nvmData <= CONTENT[nvmAddr*8 +: 8];
      end else begin
         nvmData <= ~nvmData;
      end
   end
endmodule

// >>> verif/test_selftest_and_soft_reset_control.sv
`timescale 1ns/10ps
module test_selftest_and_soft_reset_control;
   localparam logic [39:0] NVM_BYTES = 40'h5A_C3_69_F0_1E;
   localparam logic [7:0] PC = selftest_pkg::POWER_CONTROL_ADDR;
   localparam logic [7:0] ST = selftest_pkg::SELF_TEST_CONTROL_ADDR;
   localparam logic [7:0] RC = selftest_pkg::SOFTWARE_RESET_COMMAND_ADDR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   selftest_pkg::reg_req_type regReq = '0;
   // Race input high through the power-on load, which must stay clean regardless
   logic raceEvent = 1'b1;
   logic [7:0] regRdata, nvmData, q, d;
   logic [2:0] nvmAddr;
   logic standbyMode, datapathRun, tempOff, dataReadyOff;
   logic selftestModeEnable, selftestForceEnable, softResetPulse, loadBusy;
   selftest_pkg::shadow_bank_type shadowBank;
   selftest_pkg::shadow_bank_type shadowLate;
   logic [7:0] stored [5];
   int n_mismatch = 0;
   int check_count = 0;
   int tries;

   // Arbitrary early revision, inside the race range, so the retry path is exercised
   selftest_and_soft_reset_control #(
      .SILICON_REVISION_CODE(8'h02)
   ) i_selftest_and_soft_reset_control (
      .clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata), .raceEvent(raceEvent),
      .nvmData(nvmData), .nvmAddr(nvmAddr), .standbyMode(standbyMode),
      .datapathRun(datapathRun), .tempOff(tempOff), .dataReadyOff(dataReadyOff),
      .selftestModeEnable(selftestModeEnable), .selftestForceEnable(selftestForceEnable),
      .softResetPulse(softResetPulse), .loadBusy(loadBusy), .shadowBank(shadowBank)
   );
   // Later silicon beside it on the same traffic; its loaders run in lockstep
   selftest_and_soft_reset_control i_selftest_and_soft_reset_control_late (
      .clk(clk), .rst(rst), .regReq(regReq), .regRdata(), .raceEvent(raceEvent),
      .nvmData(nvmData), .nvmAddr(), .standbyMode(), .datapathRun(), .tempOff(),
      .dataReadyOff(), .selftestModeEnable(), .selftestForceEnable(),
      .softResetPulse(), .loadBusy(), .shadowBank(shadowLate)
   );
   nvm_model #(.CONTENT(NVM_BYTES)) i_nvm_model (.clk(clk), .nvmAddr(nvmAddr), .nvmData(nvmData));

   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end

   function automatic logic [7:0] nvm_byte(int i);
      return NVM_BYTES[i*8 +: 8];
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Host accesses launch at the falling edge and last one cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      regReq.addr = a;
      regReq.wdata = v;
      regReq.write = 1'b1;
      @(negedge clk);
      regReq.write = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      regReq.addr = a;
      regReq.read = 1'b1;
      @(negedge clk);
      regReq.read = 1'b0;
      v = regRdata;
   endtask

   // Bounded wait so a stuck loader cannot hang the run
   task automatic wait_load;
      int n = 0;
      while (loadBusy !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(n < 20, 1'b1);
   endtask

   // Host recovery loop: reset again until every shadow byte matches the snapshot
   task automatic soft_reset(output int t);
      logic same;
      t = 0;
      do begin
         t++;
         wr(RC, 8'h52);
         chk(softResetPulse, 1'b1);
         @(negedge clk);
         chk({loadBusy, standbyMode, datapathRun, selftestForceEnable, selftestModeEnable}, 8'h18);
         wait_load;
         same = 1'b1;
         for (int i = 0; i < 5; i++) begin
            rd(8'h50 + i[7:0], q);
            if (q !== stored[i]) same = 1'b0;
            chk(shadowLate[i], nvm_byte(i));
         end
         // The race strikes at most once here, so the retry must converge
         raceEvent = 1'b0;
      end while (!same && t < 4);
   endtask

   // Main sequence
   initial begin
      void'($urandom(86));
      repeat (16) @(negedge clk);
      chk({standbyMode, datapathRun, tempOff, selftestModeEnable, selftestForceEnable}, 8'h14);
      rst = 1'b0;
      @(negedge clk);
      wait_load;
      for (int i = 0; i < 5; i++) begin
         rd(8'h50 + i[7:0], stored[i]);
         chk(stored[i], nvm_byte(i));
      end
      rd(ST, q);
      chk(q, 8'h00);
      // Both extremes first, then random bytes; reserved bits must read back zero
      for (int k = 0; k < 10; k++) begin
         d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
         raceEvent = 1'($urandom);
         wr(ST, d);
         chk({selftestForceEnable, selftestModeEnable}, d[1:0]);
         rd(ST, q);
         chk(q, d & 8'h03);
      end
      wr(PC, 8'h00);
      chk({standbyMode, datapathRun, tempOff}, 8'h02);
      // Reserved bits dropped, temperature and ready flag off while measuring
      wr(PC, 8'hFE);
      chk({standbyMode, datapathRun, tempOff, dataReadyOff}, 8'h07);
      wr(PC, 8'h01);
      chk({standbyMode, datapathRun, tempOff}, 8'h05);
      wr(PC, 8'h00);
      wr(ST, 8'h03);
      repeat (6) begin
         d = 8'($urandom);
         if (d == 8'h52) d = 8'h53;
         wr(RC, d);
         chk({softResetPulse, selftestForceEnable, selftestModeEnable}, 8'h03);
      end
      rd(RC, q);
      chk(q, 8'h00);
      rd(8'h30, q);
      chk(q, 8'h00);
      // Race input high on early silicon: the first reload goes wrong, one retry mends it
      raceEvent = 1'b1;
      soft_reset(tries);
      chk(tries[7:0], 8'h02);
      raceEvent = 1'b0;
      soft_reset(tries);
      chk(tries[7:0], 8'h01);
      chk(shadowBank[4], nvm_byte(4));
      end_of_test;
   end

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #2000000;
      n_mismatch++;
      end_of_test;
   end

   task automatic end_of_test;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
endmodule

// >>> verilog/nvm_shadow_loader.sv
`timescale 1ns/10ps
// Copies the factory bytes from NVM into the shadow bank, one byte every two cycles.
// The NVM macro returns the addressed byte on the clock after the address.
module nvm_shadow_loader (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic softLoad,
   input wire logic raceHazard,
   input wire logic [7:0] nvmData,
   output logic [2:0] nvmAddr,
   output logic busy,
   output selftest_pkg::shadow_bank_type shadowBank
);

   typedef enum logic [1:0] {IDLE, ADDRESS, CAPTURE} load_state_type;

   load_state_type state_r;
   logic [2:0] index_r;
   logic softLoad_r;

   assign busy = (state_r != IDLE);
   assign nvmAddr = index_r;

   // Sequencer; a new start restarts the copy from the first byte
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= IDLE;
         index_r <= 3'h0;
         softLoad_r <= 1'b0;
      end else if (start) begin
         state_r <= ADDRESS;
         index_r <= 3'h0;
         softLoad_r <= softLoad;
      end else begin
         case (state_r)
            IDLE: state_r <= IDLE;
            ADDRESS: state_r <= CAPTURE;
            CAPTURE: begin
               if (index_r == 3'(selftest_pkg::SHADOW_COUNT - 1)) begin
                  state_r <= IDLE;
               end else begin
                  index_r <= index_r + 3'h1;
                  state_r <= ADDRESS;
               end
            end
            default: state_r <= IDLE;
         endcase
      end
   end

   // Capture; only a soft-reset load on early silicon can be hit by the race
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shadowBank <= '0;
      end else if (state_r == CAPTURE) begin
         if (softLoad_r && raceHazard) begin
            shadowBank[index_r] <= nvmData ^ selftest_pkg::RACE_CORRUPT_MASK;
         end else begin
            shadowBank[index_r] <= nvmData;
         end
      end
   end

   // A power-on copy must land byte for byte, whatever the race input does
   AST_CLEAN_CAPTURE: assert property (@(posedge clk) disable iff (rst)
      (state_r == CAPTURE && !softLoad_r) |=> (shadowBank[$past(index_r)] == $past(nvmData)))
      else $error("power-on shadow byte not copied as stored");

endmodule

// >>> verilog/selftest_and_soft_reset_control.sv
`timescale 1ns/10ps
// Summary of operation
// - While standby is 1 the part sits in low power with both datapaths halted, and 0 selects measurement.
// - Self test mode enable is bit 0 of the self test register, resets to zero, and writing one turns it on.
// - Self test force enable is bit 1 of the self test register, read/write, resets to zero, and one applies it.
// - Writing 0x52 to the eight-bit write-only reset register resets the whole part as at power-on.
// - After power-on and after a soft reset the factory bytes are copied from NVM into shadow registers used by the logic.
// - Power-on loads are always good, but on early silicon a soft reset load may pick up wrong values through a race.
module selftest_and_soft_reset_control #(
   // Arbitrary revision value; compared with RACE_REVISION_LAST to gate the soft reset race
   parameter logic [7:0] SILICON_REVISION_CODE = 8'h03,
   // Arbitrary last revision still exposed to the soft reset race
   parameter logic [7:0] RACE_REVISION_LAST = 8'h02
) (
   input wire logic clk,
   input wire logic rst,
   input wire selftest_pkg::reg_req_type regReq,
   output logic [7:0] regRdata,
   input wire logic raceEvent,
   input wire logic [7:0] nvmData,
   output logic [2:0] nvmAddr,
   output logic standbyMode,
   output logic datapathRun,
   output logic tempOff,
   output logic dataReadyOff,
   output logic selftestModeEnable,
   output logic selftestForceEnable,
   output logic softResetPulse,
   output logic loadBusy,
   output selftest_pkg::shadow_bank_type shadowBank
);

   logic [7:0] powerControl_r;
   logic [7:0] selfTestControl_r;
   logic [7:0] regRdata_r;
   logic softReset_r;
   logic porStart_r;
   logic raceMeta_r;
   logic raceSync_r;
   logic writeHit;
   logic loadStart;

   // Bound for the load check; a delay range cannot take a scoped name
   localparam int LOAD_WAIT_MAX = selftest_pkg::LOAD_CYCLES_MAX;

   // Shadow window decode, used by read mux and by the checks
   function automatic logic isShadow(input logic [7:0] addr);
      isShadow = (addr >= selftest_pkg::SHADOW_FIRST_ADDR) &&
                 (addr <= selftest_pkg::SHADOW_LAST_ADDR);
   endfunction

   assign writeHit = regReq.write && (regReq.addr == selftest_pkg::SOFTWARE_RESET_COMMAND_ADDR);

   // Reset command: only the exact code fires, the byte itself is never stored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         softReset_r <= 1'b0;
      end else begin
         softReset_r <= writeHit && (regReq.wdata == selftest_pkg::SOFT_RESET_CODE);
      end
   end

   assign softResetPulse = softReset_r;

   // Power-on load request, raised by reset and dropped one cycle after release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         porStart_r <= 1'b1;
      end else begin
         porStart_r <= 1'b0;
      end
   end

   assign loadStart = porStart_r || softReset_r;

   // Race indicator arrives from analog timing, so it is synchronised first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         raceMeta_r <= 1'b0;
         raceSync_r <= 1'b0;
      end else begin
         raceMeta_r <= raceEvent;
         raceSync_r <= raceMeta_r;
      end
   end

   // Power control; soft reset returns it to standby like power-on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         powerControl_r <= selftest_pkg::POWER_CONTROL_RESET;
      end else if (softReset_r) begin
         powerControl_r <= selftest_pkg::POWER_CONTROL_RESET;
      end else if (regReq.write && regReq.addr == selftest_pkg::POWER_CONTROL_ADDR) begin
         powerControl_r <= regReq.wdata & selftest_pkg::POWER_CONTROL_MASK;
      end
   end

   // Self test enables; reserved bits never store
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         selfTestControl_r <= selftest_pkg::SELF_TEST_CONTROL_RESET;
      end else if (softReset_r) begin
         selfTestControl_r <= selftest_pkg::SELF_TEST_CONTROL_RESET;
      end else if (regReq.write && regReq.addr == selftest_pkg::SELF_TEST_CONTROL_ADDR) begin
         selfTestControl_r <= regReq.wdata & selftest_pkg::SELF_TEST_CONTROL_MASK;
      end
   end

   assign standbyMode = powerControl_r[selftest_pkg::STANDBY_BIT];
   // The measurement datapath also waits for the shadow copy, since it runs from it; temperature does not
   assign datapathRun = !standbyMode && !loadBusy;
   // Temperature stops too whenever standby holds
   assign tempOff = powerControl_r[selftest_pkg::TEMP_OFF_BIT] || standbyMode;
   assign dataReadyOff = powerControl_r[selftest_pkg::DRDY_OFF_BIT];
   assign selftestModeEnable = selfTestControl_r[selftest_pkg::SELFTEST_MODE_BIT];
   assign selftestForceEnable = selfTestControl_r[selftest_pkg::SELFTEST_FORCE_BIT];

   // Read mux; data stands until the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdata_r <= selftest_pkg::READ_ZERO;
      end else if (regReq.read) begin
         if (regReq.addr == selftest_pkg::POWER_CONTROL_ADDR) begin
            regRdata_r <= powerControl_r;
         end else if (regReq.addr == selftest_pkg::SELF_TEST_CONTROL_ADDR) begin
            regRdata_r <= selfTestControl_r;
         end else if (isShadow(regReq.addr)) begin
            regRdata_r <= shadowBank[3'(regReq.addr - selftest_pkg::SHADOW_FIRST_ADDR)];
         end else begin
            regRdata_r <= selftest_pkg::READ_ZERO;
         end
      end
   end

   assign regRdata = regRdata_r;

   // Copy engine; the race only matters on early silicon
   nvm_shadow_loader loader (
      .clk(clk),
      .rst(rst),
      .start(loadStart),
      .softLoad(softReset_r),
      .raceHazard(raceSync_r && (SILICON_REVISION_CODE <= RACE_REVISION_LAST)),
      .nvmData(nvmData),
      .nvmAddr(nvmAddr),
      .busy(loadBusy),
      .shadowBank(shadowBank)
   );

   AST_STANDBY_HALTS: assert property (@(posedge clk) disable iff (rst)
      standbyMode |-> (!datapathRun && tempOff))
      else $error("datapath running in standby");

   AST_SELFTEST_MODE_WRITE: assert property (@(posedge clk) disable iff (rst)
      (regReq.write && regReq.addr == selftest_pkg::SELF_TEST_CONTROL_ADDR && !softReset_r)
      |=> (selftestModeEnable == $past(regReq.wdata[0])))
      else $error("self test mode bit not written");

   AST_SELFTEST_FORCE_HOLD: assert property (@(posedge clk) disable iff (rst)
      (!softReset_r && !(regReq.write && regReq.addr == selftest_pkg::SELF_TEST_CONTROL_ADDR))
      |=> $stable(selftestForceEnable))
      else $error("self test force changed without write");

   AST_RESET_CODE_FIRES: assert property (@(posedge clk) disable iff (rst)
      (writeHit && regReq.wdata == selftest_pkg::SOFT_RESET_CODE)
      |=> softResetPulse ##1 (standbyMode && !selftestModeEnable && !selftestForceEnable))
      else $error("reset code did not reset the part");

   AST_OTHER_CODE_IGNORED: assert property (@(posedge clk) disable iff (rst)
      (writeHit && regReq.wdata != selftest_pkg::SOFT_RESET_CODE) |=> !softResetPulse)
      else $error("wrong code caused a reset");

   AST_RESET_REG_READS_ZERO: assert property (@(posedge clk) disable iff (rst)
      (regReq.read && regReq.addr == selftest_pkg::SOFTWARE_RESET_COMMAND_ADDR)
      |=> (regRdata == selftest_pkg::READ_ZERO))
      else $error("reset register read not zero");

   AST_LOAD_AFTER_SOFT_RESET: assert property (@(posedge clk) disable iff (rst)
      softResetPulse |=> loadBusy ##[1:LOAD_WAIT_MAX] !loadBusy)
      else $error("shadow load missing or too long");

   AST_SHADOW_READBACK: assert property (@(posedge clk) disable iff (rst)
      (regReq.read && isShadow(regReq.addr) && !loadBusy && !loadStart)
      |=> (regRdata == $past(shadowBank[3'(regReq.addr - selftest_pkg::SHADOW_FIRST_ADDR)])))
      else $error("shadow read mismatch");

   AST_NO_RACE_LATE_REV: assert property (@(posedge clk) disable iff (rst)
      (SILICON_REVISION_CODE > RACE_REVISION_LAST) |-> !loader.raceHazard)
      else $error("race possible on late silicon");

   // Field writes; a soft reset in the same cycle wins, so those cycles are left out
   // Host traffic may land back to back, so each write is checked on its own edge
   AST_POWER_WRITE: assert property (@(posedge clk) disable iff (rst)
      (regReq.write && regReq.addr == selftest_pkg::POWER_CONTROL_ADDR && !softReset_r)
      |=> (standbyMode == $past(regReq.wdata[selftest_pkg::STANDBY_BIT])))
      else $error("standby field not written");

   AST_TEMP_OFF_WRITE: assert property (@(posedge clk) disable iff (rst)
      (regReq.write && regReq.addr == selftest_pkg::POWER_CONTROL_ADDR && !softReset_r)
      |=> (tempOff == ($past(regReq.wdata[1]) || $past(regReq.wdata[0]))))
      else $error("temperature not halted as written");

   AST_MEASURE_RUNS: assert property (@(posedge clk) disable iff (rst)
      (!standbyMode && !loadBusy) |-> datapathRun)
      else $error("datapath halted in measurement mode");

   AST_SELFTEST_FORCE_WRITE: assert property (@(posedge clk) disable iff (rst)
      (regReq.write && regReq.addr == selftest_pkg::SELF_TEST_CONTROL_ADDR && !softReset_r)
      |=> (selftestForceEnable == $past(regReq.wdata[1])))
      else $error("self test force bit not written");

   AST_LOAD_AFTER_POWER_ON: assert property (@(posedge clk) disable iff (rst)
      porStart_r |=> loadBusy)
      else $error("no shadow load after power-on");

   AST_SHADOW_STANDS: assert property (@(posedge clk) disable iff (rst)
      !loadBusy |=> $stable(shadowBank))
      else $error("shadow bank changed outside a load");

endmodule

// >>> verilog/selftest_pkg.sv
package selftest_pkg;

   // Register offsets on the serial register port
   localparam logic [7:0] POWER_CONTROL_ADDR = 8'h2D;
   localparam logic [7:0] SELF_TEST_CONTROL_ADDR = 8'h2E;
   localparam logic [7:0] SOFTWARE_RESET_COMMAND_ADDR = 8'h2F;
   localparam logic [7:0] SHADOW_FIRST_ADDR = 8'h50;
   localparam logic [7:0] SHADOW_LAST_ADDR = 8'h54;
   localparam int SHADOW_COUNT = 5;

   // Reset values
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h01;
   localparam logic [7:0] SELF_TEST_CONTROL_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Field positions
   localparam int STANDBY_BIT = 0;
   localparam int TEMP_OFF_BIT = 1;
   localparam int DRDY_OFF_BIT = 2;
   localparam int SELFTEST_MODE_BIT = 0;
   localparam int SELFTEST_FORCE_BIT = 1;
   localparam logic [7:0] POWER_CONTROL_MASK = 8'h07;
   localparam logic [7:0] SELF_TEST_CONTROL_MASK = 8'h03;

   // Soft reset code
   localparam logic [7:0] SOFT_RESET_CODE = 8'h52;

   // Bit flipped in a shadow byte when the soft reset race strikes
   localparam logic [7:0] RACE_CORRUPT_MASK = 8'h01;

   // Longest time from soft reset command to loaded shadow registers, in cycles
   localparam int LOAD_CYCLES_MAX = 12;

   // One access from the serial interface decoder
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
   } reg_req_type;

   typedef logic [SHADOW_COUNT-1:0][7:0] shadow_bank_type;

endpackage
